// ===== verif/ncf_core_bench.sv
// self-checking bench for the nibble datapath core
module ncf_core_bench
  import ncf_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  `define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
    $display("ERROR %0t: got %h expected %h", $time, g, e); end end

  // stimulus; all but the free-running clock driven by the bench at rising edges
  logic          clock             = 1'b0;
  logic          sys_rst           = 1'b1;
  logic          cmd_valid         = 1'b0;
  ncf_cmd_type   cmd               = '0;
  logic          irq_accept        = 1'b0;
  logic [3:0]    input_nibble_port = 4'h0;
  // observed state
  logic [3:0]    accumulator_reg;
  ncf_flags_type flags;
  logic [3:0]    output_latch_low;
  logic [3:0]    output_latch_high;
  logic [3:0]    read_data;
  logic [3:0]    half_data;
  logic          branch_taken;
  logic [11:0]   table_pointer;
  logic [7:0]    stack_addr;
  int            n_errors  = 0;
  int            tests_run = 0;

  // 40 mhz clock
  always #12.5 clock = ~clock;

  ncf_core dut (
    .clock(clock), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .irq_accept(irq_accept), .input_nibble_port(input_nibble_port),
    .accumulator_reg(accumulator_reg), .flags(flags),
    .output_latch_low(output_latch_low),
    .output_latch_high(output_latch_high), .read_data(read_data),
    .branch_taken(branch_taken), .table_pointer(table_pointer),
    .stack_addr(stack_addr));

  // small variant sees the same stream; only its memory reads are judged
  ncf_core #(.HALF_RAM(1'b1)) dut_half (
    .clock(clock), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd(cmd),
    .irq_accept(irq_accept), .input_nibble_port(input_nibble_port),
    .accumulator_reg(), .flags(), .output_latch_low(),
    .output_latch_high(), .read_data(half_data), .branch_taken(),
    .table_pointer(), .stack_addr());

  // one instruction, taken at the following edge
  task automatic op(input ncf_op_type o, input logic [3:0] v = 4'h0,
                    input logic [7:0] a = 8'h00, input logic [4:0] p = 5'h00);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd       <= '{o, v, a, p};
  endtask

  // idle edges; the first one takes the last queued instruction
  task automatic settle(input int n = 1);
    repeat (n) begin
      @(posedge clock);
      cmd_valid <= 1'b0;
    end
    #1;
  endtask

  task automatic mark(input string s);
    $display("test %s finished, mismatches so far %0d", s, n_errors);
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clock);
    n_errors++;
    $display("ERROR %0t: run did not finish", $time);
    test_done();
  end

  initial begin
    ncf_op_type t_op [8] = '{NCF_ADD, NCF_ADD, NCF_ADD_WITH_CARRY_OP, NCF_SUBR,
                             NCF_SUBTRACT_WITH_CARRY_OP, NCF_SUBR, NCF_SUBTRACT_WITH_CARRY_OP, NCF_ADD_WITH_CARRY_OP};
    logic [3:0] t_acc [8] = '{4'h4, 4'h7, 4'h9, 4'h1, 4'h2, 4'h8, 4'h8,
                              4'h8};
    logic [3:0] t_mem [8] = '{4'h5, 4'h9, 4'h8, 4'h3, 4'h2, 4'h6, 4'h5,
                              4'h8};
    logic [7:0] cells [9] = '{8'hf4, 8'hf5, 8'hf6, 8'hf8, 8'hf9, 8'hfa,
                              8'hfc, 8'hfd, 8'hfe};
    logic       sub;
    logic       cin;
    logic       cy;
    logic [4:0] sum;
    repeat (20) @(posedge clock);
    sys_rst <= 1'b0;
    #1;
    `CHK(flags, 4'h2);
    `CHK(accumulator_reg, 4'h0);
    `CHK(branch_taken, 1'b0);
    mark("reset");
    // alu cases; the carry flag moves only on carry ops
    cy = 1'b0;
    for (int k = 0; k < 8; k++) begin
      op(NCF_LD_IMM, t_mem[k]);
      op(NCF_ST_MEM, , 8'h10);
      op(NCF_LD_IMM, t_acc[k]);
      op(t_op[k], , 8'h10);
      settle();
      sub = t_op[k] inside {NCF_SUBR, NCF_SUBTRACT_WITH_CARRY_OP};
      cin = (t_op[k] inside {NCF_ADD_WITH_CARRY_OP, NCF_SUBTRACT_WITH_CARRY_OP}) ? cy : sub;
      sum = {1'b0, t_acc[k] ^ {4{sub}}} + {1'b0, t_mem[k]} + {4'h0, cin};
      // plain add and subtract leave the carry flag alone
      if (t_op[k] inside {NCF_ADD_WITH_CARRY_OP, NCF_SUBTRACT_WITH_CARRY_OP}) cy = sum[4];
      `CHK(accumulator_reg, sum[3:0]);
      `CHK(flags, {cy, sum[3:0] == 4'h0, sum[4] ^ ~sub, 1'b0});
    end
    mark("alu");
    // special cells: counters then table pointer, high nibble on top
    for (int k = 0; k < 9; k++) begin
      op(NCF_LD_IMM, 4'(k + 1));
      op(NCF_ST_MEM, , cells[k]);
    end
    settle(2);
    `CHK(table_pointer, 12'h987);
    for (int k = 0; k < 9; k++) begin
      op(NCF_LD_MEM, , cells[k]);
      settle();
      `CHK(read_data, 4'(k + 1));
    end
    op(NCF_LD_IMM, 4'h9);
    op(NCF_ST_MEM, , 8'h23);
    op(NCF_LD_MEM, , 8'ha3);
    settle();
    `CHK(half_data, 4'h9);
    mark("cells");
    // interrupt right after an add that cleared status, then return
    op(NCF_LD_IMM, 4'hc);
    op(NCF_ST_MEM, , 8'hff);
    settle(2);
    `CHK(stack_addr, 8'hf0);
    op(NCF_LD_IMM, 4'h7);
    op(NCF_ST_MEM, , 8'h10);
    op(NCF_LD_IMM, 4'h9);
    op(NCF_ADD, , 8'h10);
    @(posedge clock);
    cmd_valid  <= 1'b0;
    irq_accept <= 1'b1;
    @(posedge clock);
    irq_accept <= 1'b0;
    #1;
    `CHK(flags.branch_status_bit, 1'b1);
    `CHK(stack_addr, 8'hec);
    op(NCF_LD_MEM, , 8'hff);
    settle();
    `CHK(read_data, 4'hb);
    op(NCF_LD_MEM, , 8'hf0);
    op(NCF_GF_SET);
    op(NCF_RETURN);
    settle();
    `CHK(read_data, 4'hc);
    `CHK(flags, 4'hc);
    `CHK(stack_addr, 8'hf0);
    // return in the very cycle after acceptance; idle edge set status
    @(posedge clock);
    irq_accept <= 1'b1;
    op(NCF_RETURN);
    irq_accept <= 1'b0;
    settle();
    `CHK(flags, 4'he);
    `CHK(stack_addr, 8'hf0);
    mark("interrupt");
    // branch follows the general flag test
    op(NCF_GF_CLR);
    op(NCF_GF_TEST);
    op(NCF_BRANCH);
    settle();
    `CHK(branch_taken, 1'b0);
    op(NCF_GF_SET);
    op(NCF_GF_TEST);
    op(NCF_BRANCH);
    settle();
    `CHK(branch_taken, 1'b1);
    `CHK(flags.general_flag_bit, 1'b1);
    settle();
    `CHK(flags.branch_status_bit, 1'b1);
    mark("branch");
    // rotates through carry, carry is one from the return
    op(NCF_LD_IMM, 4'h6);
    op(NCF_ROTL);
    settle();
    `CHK({flags.carry_flag_bit, accumulator_reg}, 5'h0d);
    op(NCF_ROTR);
    settle();
    `CHK({flags.carry_flag_bit, accumulator_reg}, 5'h16);
    mark("rotate");
    // port latches, a write to a plain port, unlatched input
    op(NCF_LD_IMM, 4'h7);
    op(NCF_OUT, , , 5'h01);
    op(NCF_LD_IMM, 4'hc);
    op(NCF_OUT, , , 5'h02);
    op(NCF_LD_IMM, 4'h5);
    op(NCF_OUT, , , 5'h03);
    settle();
    `CHK({output_latch_high, output_latch_low}, 8'hc7);
    op(NCF_IN, , , 5'h01);
    settle();
    `CHK(read_data, 4'h7);
    op(NCF_IN, , , 5'h05);
    settle();
    `CHK(read_data, 4'h0);
    op(NCF_IN, , , 5'h00);
    input_nibble_port <= 4'hb;
    settle();
    `CHK(read_data, 4'hb);
    op(NCF_IN, , , 5'h00);
    input_nibble_port <= 4'h0;
    settle();
    `CHK({read_data, flags.zero_flag_bit}, 5'h01);
    mark("ports");
    test_done();
  end
endmodule

// ===== verilog/ncf_core.sv
// accumulator, alu, flags, special ram cells and port latches
`include "ncf_map.svh"

module ncf_core
  import ncf_pkg::*;
#(
  parameter bit HALF_RAM = 1'b0
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          sys_rst,
  // instruction stream
  input  wire logic          cmd_valid,
  input  wire ncf_cmd_type   cmd,
  input  wire logic          irq_accept,
  // input port
  input  wire logic [3:0]    input_nibble_port,
  // state seen outside
  output logic      [3:0]    accumulator_reg,
  output ncf_flags_type      flags,
  output logic      [3:0]    output_latch_low,
  output logic      [3:0]    output_latch_high,
  output logic      [3:0]    read_data,
  output logic               branch_taken,
  output logic      [11:0]   table_pointer,
  output logic      [7:0]    stack_addr
);

  // folds the top address bit on the small variant
  function automatic logic [7:0] ram_index(input logic [7:0] a);
    ram_index = HALF_RAM ? (a & `NCF_RAM_FOLD_MASK) : a;
  endfunction

  function automatic logic is_zero(input logic [3:0] v);
    is_zero = (v == `NCF_NIBBLE_ZERO);
  endfunction

  // 256 nibbles; the level word cell lives in its own register
  logic [3:0]    ram [0:255];
  logic [3:0]    stack_level_word;
  logic [3:0]    next_spw;
  logic [3:0]    next_acc;
  ncf_flags_type next_flags;

  // command decode
  wire       run       = cmd_valid & ~irq_accept;
  wire       do_return = run & (cmd.op == NCF_RETURN);
  wire [7:0] mem_idx   = ram_index(cmd.addr);
  wire [7:0] spw_idx   = ram_index(`NCF_ADDR_SPW);
  wire       hit_spw   = (mem_idx == spw_idx);
  wire [3:0] mem_val   = hit_spw ? stack_level_word : ram[mem_idx];
  wire       mem_wr    = run & (cmd.op == NCF_ST_MEM);

  // stack slot: save uses the current level, restore the next
  wire [3:0] spw_up    = stack_level_word + 4'h1;
  wire [7:0] save_addr = {`NCF_STACK_PREFIX, stack_level_word,
                          `NCF_STACK_SUFFIX};
  wire [7:0] rest_addr = {`NCF_STACK_PREFIX, spw_up,
                          `NCF_STACK_SUFFIX};
  wire [3:0] rest_val  = ram[ram_index(rest_addr)];

  // alu: subtraction is memory plus inverted accumulator
  wire       cin_sub   = (cmd.op == NCF_SUBTRACT_WITH_CARRY_OP) ?
                         flags.carry_flag_bit : 1'b1;
  wire       cin_add   = (cmd.op == NCF_ADD_WITH_CARRY_OP) ?
                         flags.carry_flag_bit : 1'b0;
  wire [4:0] sum_add   = {1'b0, accumulator_reg} + {1'b0, mem_val}
                         + {4'h0, cin_add};
  wire [4:0] sum_sub   = {1'b0, mem_val} + {1'b0, ~accumulator_reg}
                         + {4'h0, cin_sub};

  // port decode, independent of memory addresses
  wire       prt_lo    = (cmd.port == `NCF_PORT_LATCH_LO);
  wire       prt_hi    = (cmd.port == `NCF_PORT_LATCH_HI);
  wire       prt_in    = (cmd.port == `NCF_PORT_INPUT);
  wire [3:0] port_val  = prt_in ? input_nibble_port :
                         prt_lo ? output_latch_low :
                         prt_hi ? output_latch_high :
                         `NCF_NIBBLE_ZERO;
  wire       out_lo    = run & (cmd.op == NCF_OUT) & prt_lo;
  wire       out_hi    = run & (cmd.op == NCF_OUT) & prt_hi;

  // next accumulator and flags; status defaults to one
  always_comb begin
    next_acc   = accumulator_reg;
    next_flags = flags;
    next_flags.branch_status_bit = 1'b1;
    if (irq_accept) begin
      next_flags.branch_status_bit = 1'b1;
    end else if (cmd_valid) begin
      case (cmd.op)
        NCF_LD_IMM: begin
          next_acc = cmd.imm;
          next_flags.zero_flag_bit = is_zero(cmd.imm);
        end
        NCF_LD_MEM: begin
          next_acc = mem_val;
          next_flags.zero_flag_bit = is_zero(mem_val);
        end
        NCF_IN: begin
          next_acc = port_val;
          next_flags.zero_flag_bit = is_zero(port_val);
        end
        NCF_ADD, NCF_ADD_WITH_CARRY_OP: begin
          next_acc = sum_add[3:0];
          next_flags.zero_flag_bit = is_zero(sum_add[3:0]);
          next_flags.branch_status_bit = ~sum_add[4];
          if (cmd.op == NCF_ADD_WITH_CARRY_OP) begin
            next_flags.carry_flag_bit = sum_add[4];
          end
        end
        NCF_SUBR, NCF_SUBTRACT_WITH_CARRY_OP: begin
          next_acc = sum_sub[3:0];
          next_flags.zero_flag_bit = is_zero(sum_sub[3:0]);
          next_flags.branch_status_bit = sum_sub[4];
          if (cmd.op == NCF_SUBTRACT_WITH_CARRY_OP) begin
            next_flags.carry_flag_bit = sum_sub[4];
          end
        end
        NCF_ROTL: begin
          next_acc = {accumulator_reg[2:0], flags.carry_flag_bit};
          next_flags.carry_flag_bit = accumulator_reg[3];
        end
        NCF_ROTR: begin
          next_acc = {flags.carry_flag_bit, accumulator_reg[3:1]};
          next_flags.carry_flag_bit = accumulator_reg[0];
        end
        NCF_GF_SET: next_flags.general_flag_bit = 1'b1;
        NCF_GF_CLR: next_flags.general_flag_bit = 1'b0;
        NCF_GF_TEST: begin
          next_flags.branch_status_bit = flags.general_flag_bit;
        end
        NCF_RETURN: next_flags = ncf_flags_type'(rest_val);
        default: next_acc = accumulator_reg;
      endcase
    end
  end

  // level word: down after a save, up before a restore
  always_comb begin
    next_spw = stack_level_word;
    if (irq_accept) begin
      next_spw = stack_level_word - 4'h1;
    end else if (do_return) begin
      next_spw = spw_up;
    end else if (mem_wr & hit_spw) begin
      next_spw = accumulator_reg;
    end
  end

  // ram cells: counters and table pointer are plain cells here
  always_ff @(posedge clock) begin
    if (irq_accept) begin
      ram[ram_index(save_addr)] <= flags;
    end else if (mem_wr & ~hit_spw) begin
      ram[mem_idx] <= accumulator_reg;
    end
  end

  // core registers; status starts at one
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      accumulator_reg <= `NCF_NIBBLE_ZERO;
      flags           <= ncf_flags_type'(`NCF_FLAGS_RESET);
      stack_level_word             <= `NCF_SPW_RESET;
    end else begin
      accumulator_reg <= next_acc;
      flags           <= next_flags;
      stack_level_word             <= next_spw;
    end
  end

  // branch decision uses status as left by the previous op
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      branch_taken <= 1'b0;
    end else begin
      branch_taken <= run & (cmd.op == NCF_BRANCH) &
                      flags.branch_status_bit;
    end
  end

  // output latches hold until rewritten
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      output_latch_low  <= `NCF_NIBBLE_ZERO;
      output_latch_high <= `NCF_NIBBLE_ZERO;
    end else begin
      if (out_lo) output_latch_low <= accumulator_reg;
      if (out_hi) output_latch_high <= accumulator_reg;
    end
  end

  // read-back: memory on loads, port value on inputs
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      read_data <= `NCF_NIBBLE_ZERO;
    end else if (run & (cmd.op == NCF_LD_MEM)) begin
      read_data <= mem_val;
    end else if (run & (cmd.op == NCF_IN)) begin
      read_data <= port_val;
    end
  end

  // table pointer one cycle behind the cells, stack address in step with the level word;
  // table cells are unknown until software loads them
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      table_pointer <= 12'h000;
      stack_addr    <= 8'h00;
    end else begin
      table_pointer <= {ram[ram_index(`NCF_ADDR_TBL_HIGH)],
                        ram[ram_index(`NCF_ADDR_TBL_MID)],
                        ram[ram_index(`NCF_ADDR_TBL_LOW)]};
      stack_addr    <= {`NCF_STACK_PREFIX, next_spw,
                        `NCF_STACK_SUFFIX};
    end
  end

  // checks
  spw_save_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    irq_accept |=> stack_level_word == $past(stack_level_word) - 4'h1)
    else $error("level word not lowered after save");
  spw_restore_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    do_return |=> stack_level_word == $past(stack_level_word) + 4'h1)
    else $error("level word not raised on restore");
  sf_irq_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    irq_accept |=> flags.branch_status_bit)
    else $error("status not forced after interrupt");
  zero_load_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    run && cmd.op inside {NCF_LD_IMM, NCF_ADD, NCF_SUBR}
    |=> flags.zero_flag_bit == (accumulator_reg == 4'h0))
    else $error("zero flag disagrees with accumulator");
  sub_carry_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    run && cmd.op == NCF_SUBTRACT_WITH_CARRY_OP && flags.carry_flag_bit
    |=> flags.carry_flag_bit == ($past(mem_val) >= $past(accumulator_reg)))
    else $error("carry is not no-borrow");
  branch_gate_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    run && cmd.op == NCF_BRANCH
    |=> branch_taken == $past(flags.branch_status_bit))
    else $error("branch ignored status");
  latch_low_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    out_lo |=> output_latch_low == $past(accumulator_reg)
    ##1 (!$past(out_lo) || output_latch_low == $past(output_latch_low)))
    else $error("output latch low wrong");
  gf_hold_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    run && !(cmd.op inside {NCF_GF_SET, NCF_GF_CLR, NCF_RETURN})
    |=> $stable(flags.general_flag_bit))
    else $error("general flag changed unasked");
  flag_restore_a: assert property (@(posedge clock)
    disable iff (sys_rst)
    irq_accept ##1 (run && cmd.op == NCF_RETURN)
    |=> flags == $past(flags, 2))
    else $error("flags not restored on return");

endmodule

// ===== verilog/ncf_map.svh
// offsets, field positions and reset values of the nibble datapath
`ifndef NCF_MAP_SVH
`define NCF_MAP_SVH
`define NCF_ADDR_TC1_LOW   8'h00_f4
`define NCF_ADDR_TC1_MID   8'h00_f5
`define NCF_ADDR_TC1_HIGH  8'h00_f6
`define NCF_ADDR_TC2_LOW   8'h00_f8
`define NCF_ADDR_TC2_MID   8'h00_f9
`define NCF_ADDR_TC2_HIGH  8'h00_fa
`define NCF_ADDR_TBL_LOW   8'h00_fc
`define NCF_ADDR_TBL_MID   8'h00_fd
`define NCF_ADDR_TBL_HIGH  8'h00_fe
`define NCF_ADDR_SPW       8'h00_ff
`define NCF_STACK_PREFIX   2'h3
`define NCF_STACK_SUFFIX   2'h0
`define NCF_RAM_FOLD_MASK  8'h00_7f
`define NCF_PORT_INPUT     5'h00
`define NCF_PORT_LATCH_LO  5'h01
`define NCF_PORT_LATCH_HI  5'h02
`define NCF_FLAG_CF_BIT    3
`define NCF_FLAG_ZF_BIT    2
`define NCF_FLAG_SF_BIT    1
`define NCF_FLAG_GF_BIT    0
`define NCF_FLAGS_RESET    4'h2
`define NCF_SPW_RESET      4'h0
`define NCF_NIBBLE_ZERO    4'h0
`endif

// ===== verilog/ncf_pkg.sv
// types shared by the nibble datapath and its users
package ncf_pkg;
  typedef enum logic [4:0] {
    NCF_NOP, NCF_LD_IMM, NCF_LD_MEM, NCF_ST_MEM,
    NCF_ADD, NCF_ADD_WITH_CARRY_OP, NCF_SUBR, NCF_SUBTRACT_WITH_CARRY_OP,
    NCF_ROTL, NCF_ROTR, NCF_GF_SET, NCF_GF_CLR, NCF_GF_TEST,
    NCF_BRANCH, NCF_IN, NCF_OUT, NCF_RETURN
  } ncf_op_type;

  typedef struct packed {
    logic carry_flag_bit;
    logic zero_flag_bit;
    logic branch_status_bit;
    logic general_flag_bit;
  } ncf_flags_type;

  typedef struct packed {
    ncf_op_type op;
    logic [3:0] imm;
    logic [7:0] addr;
    logic [4:0] port;
  } ncf_cmd_type;
endpackage
